// *** global_config_pin_mux.sv ***
// Global configuration registers behind the index/data ports, and the
// seven-pin multiplexer for serial modem lines, GPIO and alternate functions.
// Assumes host I/O strobes are one-cycle pulses on clk; pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module global_config_pin_mux
   import global_config_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   // Host I/O cycle port
   input  wire logic [15:0]         ioAddr,
   input  wire logic                ioWr,
   input  wire logic                ioRd,
   input  wire logic [7:0]          ioWrData,
   output var  logic [7:0]          ioRdData,
   output var  logic                ioRdValid,
   // Strap pins
   input  wire logic                serialOutStrapPin,
   // Shared pins, indexed by the pin indices of the package
   input  wire logic [NUM_PINS-1:0] pinIn,
   output var  logic [NUM_PINS-1:0] pinOut,
   output var  logic [NUM_PINS-1:0] pinOe,
   // Serial port side
   input  wire logic                uartDtrN,
   input  wire logic                uartRtsN,
   output var  logic [NUM_PINS-1:0] uartIn,
   input  wire logic                thrWrite,
   input  wire logic [15:0]         bitCycles,
   output var  logic                txStart,
   output var  logic                serialClkEn,
   // GPIO and alternate function side
   input  wire logic [NUM_PINS-1:0] gpioOut,
   input  wire logic [NUM_PINS-1:0] gpioOe,
   output var  logic [NUM_PINS-1:0] gpioIn,
   input  wire logic [NUM_PINS-1:0] altOut,
   input  wire logic [NUM_PINS-1:0] altOe,
   output var  logic [NUM_PINS-1:0] altIn,
   // Global mode outputs
   output var  logic                altConfigPort,
   output var  logic                powerGoodVariant,
   output var  logic                timingEnable,
   output var  logic                inputClockFreqSelect
);
   logic [NUM_PINS-1:0] pinMeta_q;
   logic [NUM_PINS-1:0] pinSync_q;
   logic                strapMeta_q;
   logic                strapSync_q;
   logic                strapPending_q;
   logic [7:0]          index_q;
   logic                serialClkGate_q;
   logic                inputClkFreq_q;
   logic                txDelay_q;
   logic                altPort_q;
   logic                pgVariant_q;
   logic                timingEn_q;
   logic [7:0]          multiFunc0_q;
   logic [1:0]          group_q;
   logic                ringWake_q;
   logic [15:0]         indexPort;
   logic                indexHit;
   logic                dataHit;
   logic                regWr;
   logic [7:0]          regRdData;
   logic [NUM_PINS-1:0] altSel;
   logic [NUM_PINS-1:0] serOut;
   pin_func_t           pinFunc [NUM_PINS];

   // Two-stage synchronisers for pins and the serial-output strap
   always_ff @(posedge clk) begin
      pinMeta_q   <= pinIn;
      pinSync_q   <= pinMeta_q;
      strapMeta_q <= serialOutStrapPin;
      strapSync_q <= strapMeta_q;
   end

   // Index/data port decode follows the port-select bit
   assign indexPort = altPort_q ? PORT_INDEX_ALT : PORT_INDEX_PRIMARY; // [R3]
   assign indexHit  = (ioAddr == indexPort);
   assign dataHit   = (ioAddr == indexPort + 16'h0001); // [R3]
   assign regWr     = ioWr && dataHit;

   // Index latch
   always_ff @(posedge clk) begin
      if (rst) begin
         index_q <= 8'h00;
      end else if (ioWr && indexHit) begin
         index_q <= ioWrData;
      end
   end

   // Software power-down: serial clock gate
   always_ff @(posedge clk) begin
      if (rst) begin
         serialClkGate_q <= RST_SERIAL_CLK_GATE; // [R1]
      end else if (regWr && index_q == IDX_SW_POWER_DOWN) begin
         serialClkGate_q <= ioWrData[BIT_SERIAL_CLK_GATE]; // [R1]
      end
   end

   // Clock frequency select and transmit-start delay
   always_ff @(posedge clk) begin
      if (rst) begin
         inputClkFreq_q <= RST_INPUT_CLK_FREQ;
         txDelay_q      <= RST_TX_START_DELAY;
      end else if (regWr && index_q == IDX_SERIAL_IRQ_CTRL) begin
         inputClkFreq_q <= ioWrData[BIT_INPUT_CLK_FREQ];
         txDelay_q      <= ioWrData[BIT_TX_START_DELAY]; // [R2]
      end
   end

   // Strap capture on the first cycle after reset release
   always_ff @(posedge clk) begin
      if (rst) begin
         strapPending_q <= 1'b1;
      end else begin
         strapPending_q <= 1'b0;
      end
   end

   // Port select and power-good variant: strapped, then software writable
   always_ff @(posedge clk) begin
      if (rst) begin
         altPort_q   <= 1'b0;
         pgVariant_q <= 1'b0;
      end else if (strapPending_q) begin
         altPort_q   <= strapSync_q;           // [R4]
         pgVariant_q <= pinSync_q[PIN_RTS];    // [R6]
      end else if (regWr && index_q == IDX_CONFIG_PORT_SEL) begin
         altPort_q   <= ioWrData[BIT_ALT_PORT_SELECT]; // [R3]
         pgVariant_q <= ioWrData[BIT_POWER_GOOD_VAR];  // [R5]
      end
   end

   // Timing-sequence enable
   always_ff @(posedge clk) begin
      if (rst) begin
         timingEn_q <= RST_TIMING_ENABLE; // [R7]
      end else if (regWr && index_q == IDX_CONFIG_PORT_SEL) begin
         timingEn_q <= ioWrData[BIT_TIMING_ENABLE]; // [R7]
      end
   end

   // Multi-function selects: alternate bits, group field, wake override
   always_ff @(posedge clk) begin
      if (rst) begin
         multiFunc0_q <= RST_MULTI_FUNC_0;
         group_q      <= RST_GROUP_SELECT; // [R15]
         ringWake_q   <= RST_RING_WAKE;    // [R16]
      end else if (regWr) begin
         if (index_q == IDX_MULTI_FUNC_0) begin
            multiFunc0_q <= ioWrData & MULTI_FUNC_0_MASK; // [R17]
         end
         if (index_q == IDX_MULTI_FUNC_1) begin
            group_q <= ioWrData[BIT_GROUP_LO +: 2]; // [R15]
         end
         if (index_q == IDX_MULTI_FUNC_2) begin
            ringWake_q <= ioWrData[BIT_RING_WAKE]; // [R16]
         end
      end
   end

   // Register read data; reserved bits and unmapped indices read zero
   always_comb begin
      regRdData = 8'h00; // [R17]
      case (index_q)
         IDX_SW_POWER_DOWN: begin
            regRdData[BIT_SERIAL_CLK_GATE] = serialClkGate_q;
         end
         IDX_SERIAL_IRQ_CTRL: begin
            regRdData[BIT_INPUT_CLK_FREQ] = inputClkFreq_q;
            regRdData[BIT_TX_START_DELAY] = txDelay_q;
         end
         IDX_CONFIG_PORT_SEL: begin
            regRdData[BIT_ALT_PORT_SELECT] = altPort_q;
            regRdData[BIT_POWER_GOOD_VAR]  = pgVariant_q;
            regRdData[BIT_TIMING_ENABLE]   = timingEn_q;
         end
         IDX_MULTI_FUNC_0: begin
            regRdData = multiFunc0_q;
         end
         IDX_MULTI_FUNC_1: begin
            regRdData[BIT_GROUP_LO +: 2] = group_q;
         end
         IDX_MULTI_FUNC_2: begin
            regRdData[BIT_RING_WAKE] = ringWake_q;
         end
         default: begin
            regRdData = 8'h00;
         end
      endcase
   end

   // Host read answer one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         ioRdData  <= 8'h00;
         ioRdValid <= 1'b0;
      end else begin
         ioRdValid <= ioRd && (indexHit || dataHit);
         if (ioRd && indexHit) begin
            ioRdData <= index_q;
         end else if (ioRd && dataHit) begin
            ioRdData <= regRdData;
         end
      end
   end

   // Alternate bit per pin, and serial output level per pin
   assign altSel = multiFunc0_q[NUM_PINS:0] == 8'h00 ? 7'h00 :
                   {multiFunc0_q[7], multiFunc0_q[5:0]};
   always_comb begin
      serOut          = {NUM_PINS{1'b1}};
      serOut[PIN_DTR] = uartDtrN;
      serOut[PIN_RTS] = uartRtsN;
   end

   // Function decode and pin drive, one slice per shared pin
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      always_comb begin
         if (p == PIN_RING && ringWake_q) begin
            pinFunc[p] = FN_WAKE; // [R13]
         end else if (altSel[p]) begin
            pinFunc[p] = FN_ALT; // [R8] [R9] [R10] [R11] [R12] [R13] [R14]
         end else if (p == PIN_SIN) begin
            pinFunc[p] = (group_q == GRP_ALL_GPIO) ? FN_GPIO : FN_SERIAL; // [R8]
         end else if (p == PIN_RTS) begin
            pinFunc[p] = group_q[0] ? FN_GPIO : FN_SERIAL; // [R10]
         end else begin
            pinFunc[p] = (group_q == GRP_ALL_SERIAL) ? FN_SERIAL : FN_GPIO; // [R9] [R11] [R12] [R13] [R14] [R15]
         end
      end

      // Registered pin drive and routed inputs
      always_ff @(posedge clk) begin
         if (rst) begin
            pinOut[p] <= 1'b1;
            pinOe[p]  <= 1'b0;
            uartIn[p] <= 1'b1;
            gpioIn[p] <= 1'b0;
            altIn[p]  <= 1'b0;
         end else begin
            gpioIn[p] <= pinSync_q[p];
            altIn[p]  <= pinSync_q[p];
            uartIn[p] <= (pinFunc[p] == FN_SERIAL) ? pinSync_q[p] : 1'b1;
            case (pinFunc[p])
               FN_SERIAL: begin
                  pinOut[p] <= serOut[p];
                  pinOe[p]  <= SERIAL_OUT_MASK[p];
               end
               FN_GPIO: begin
                  pinOut[p] <= gpioOut[p];
                  pinOe[p]  <= gpioOe[p];
               end
               FN_ALT: begin
                  pinOut[p] <= altOut[p];
                  pinOe[p]  <= altOe[p];
               end
               FN_WAKE: begin
                  pinOut[p] <= altOut[PIN_SIN]; // [R13]
                  pinOe[p]  <= altOe[PIN_SIN];
               end
               default: begin
                  pinOut[p] <= 1'b1;
                  pinOe[p]  <= 1'b0;
               end
            endcase
         end
      end
   end

   // Global mode outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         serialClkEn          <= 1'b1;
         altConfigPort        <= 1'b0;
         powerGoodVariant     <= 1'b0;
         timingEnable         <= RST_TIMING_ENABLE;
         inputClockFreqSelect <= RST_INPUT_CLK_FREQ;
      end else begin
         serialClkEn          <= !serialClkGate_q; // [R1]
         altConfigPort        <= altPort_q;
         powerGoodVariant     <= pgVariant_q; // [R5]
         timingEnable         <= timingEn_q;  // [R7]
         inputClockFreqSelect <= inputClkFreq_q;
      end
   end

   // Transmit start timing
   tx_start_delay u_tx_start_delay (
      .clk       (clk),
      .rst       (rst),
      .delayEn   (txDelay_q),
      .thrWrite  (thrWrite),
      .bitCycles (bitCycles),
      .txStart   (txStart)
   );
endmodule : global_config_pin_mux
`default_nettype wire

// *** global_config_pin_mux_assertions.sv ***
// Port-level checks for the global configuration and shared-pin block.
// Assumes one clock domain; host cycles follow the index/data decode.
`timescale 1ns/1ns
`default_nettype none
module global_config_pin_mux_assertions
   import global_config_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [15:0] ioAddr,
   input wire logic        ioWr,
   input wire logic        ioRd,
   input wire logic [7:0]  ioWrData,
   input wire logic        ioRdValid,
   input wire logic        thrWrite,
   input wire logic [15:0] bitCycles,
   input wire logic        txStart,
   input wire logic        serialClkEn,
   input wire logic        timingEnable,
   input wire logic        altConfigPort,
   input wire logic [6:0]  pinOut,
   input wire logic [6:0]  pinOe,
   input wire logic [6:0]  altOut,
   input wire logic [6:0]  altOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [15:0] base;
   logic [7:0]  idx_q;
   logic        idxHit, datHit, datWr, del_q, sinAlt_q, ringWake_q;
   // Decode at the pair the block answers on now
   assign base   = altConfigPort ? PORT_INDEX_ALT : PORT_INDEX_PRIMARY;
   assign idxHit = ioAddr == base;
   assign datHit = ioAddr == base + 16'h0001;
   assign datWr  = ioWr && datHit;
   // Shadow of the bits that steer the checks
   always_ff @(posedge clk) begin
      if (rst) begin
         idx_q      <= 8'h00;
         del_q      <= 1'h0;
         sinAlt_q   <= 1'h0;
         ringWake_q <= 1'h0;
      end else begin
         if (ioWr && idxHit) idx_q <= ioWrData;
         if (datWr && idx_q == IDX_SERIAL_IRQ_CTRL) del_q <= ioWrData[BIT_TX_START_DELAY];
         if (datWr && idx_q == IDX_MULTI_FUNC_0) sinAlt_q <= ioWrData[7];
         if (datWr && idx_q == IDX_MULTI_FUNC_2) ringWake_q <= ioWrData[BIT_RING_WAKE];
      end
   end
   property p_rd_answer; ioRd && (idxHit || datHit) |=> ioRdValid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_rd_refuse; ioRd && !idxHit && !datHit |=> !ioRdValid; endproperty
   a_rd_refuse: assert property (p_rd_refuse) else $error("foreign read answered");
   property p_tx_now; thrWrite && !del_q |=> txStart; endproperty
   a_tx_now: assert property (p_tx_now) else $error("prompt start missing");
   property p_tx_late; thrWrite && del_q && bitCycles == 16'h0003 |=> !txStart [*3] ##1 txStart; endproperty
   a_tx_late: assert property (p_tx_late) else $error("delayed start wrong");
   property p_clk_gate; datWr && idx_q == IDX_SW_POWER_DOWN |-> ##2 serialClkEn == !$past(ioWrData[1], 2); endproperty
   a_clk_gate: assert property (p_clk_gate) else $error("clock gate wrong");
   property p_timing; datWr && idx_q == IDX_CONFIG_PORT_SEL |-> ##2 timingEnable == $past(ioWrData[0], 2); endproperty
   a_timing: assert property (p_timing) else $error("timing enable wrong");
   property p_sin_alt; $past(sinAlt_q) |-> pinOut[6] == $past(altOut[6]) && pinOe[6] == $past(altOe[6]); endproperty
   a_sin_alt: assert property (p_sin_alt) else $error("serial-in pin not wake");
   property p_ring_wake; $past(ringWake_q) |-> pinOut[1] == $past(altOut[6]) && pinOe[1] == $past(altOe[6]); endproperty
   a_ring_wake: assert property (p_ring_wake) else $error("ring pin not wake");
endmodule : global_config_pin_mux_assertions
bind global_config_pin_mux global_config_pin_mux_assertions u_chk (.*);
`default_nettype wire

// *** global_config_pkg.sv ***
// Constants for the global configuration and shared-pin multiplexer block.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
// Notes on behaviour
// R1 - Clock gate bit stops serial clock, resets zero
// R2 - Delay bit defers transmit start one bit
// R3 - Port-select bit picks index/data pair 2E or 4E
// R4 - Port-select loaded from serial-output strap at power-on
// R5 - Power-good variant bit picks first or second sequence
// R6 - Power-good variant latched from shared strap pin
// R7 - Timing-sequence enable resets one, clearing disables
// R8 - Serial-input pin: serial, GPIO or wake button
// R9 - Data-set-ready pin: serial, GPIO or beeper
// R10 - Request-to-send pin uses low group bit only
// R11 - Data-terminal-ready pin: serial, GPIO or infrared transmit
// R12 - Clear-to-send pin: serial, GPIO or indicator LED
// R13 - Ring pin: wake override, else serial/GPIO/over-temperature
// R14 - Carrier-detect pin: serial, GPIO or serial-bus data
// R15 - Group field resets to 3, selects pin grouping
// R16 - Wake override at bit 7 of next register
// R17 - Reserved bits read zero, ignore writes
package global_config_pkg;

   // Register indices
   localparam logic [7:0] IDX_SW_POWER_DOWN   = 8'h25;
   localparam logic [7:0] IDX_SERIAL_IRQ_CTRL = 8'h26;
   localparam logic [7:0] IDX_CONFIG_PORT_SEL = 8'h27;
   localparam logic [7:0] IDX_MULTI_FUNC_0    = 8'h28;
   localparam logic [7:0] IDX_MULTI_FUNC_1    = 8'h29;
   localparam logic [7:0] IDX_MULTI_FUNC_2    = 8'h2a;

   // Field positions
   localparam int BIT_SERIAL_CLK_GATE   = 1;
   localparam int BIT_INPUT_CLK_FREQ    = 7;
   localparam int BIT_TX_START_DELAY    = 2;
   localparam int BIT_ALT_PORT_SELECT   = 4;
   localparam int BIT_POWER_GOOD_VAR    = 1;
   localparam int BIT_TIMING_ENABLE     = 0;
   localparam int BIT_GROUP_LO          = 6;
   localparam int BIT_RING_WAKE         = 7;
   localparam logic [7:0] MULTI_FUNC_0_MASK = 8'hbf;

   // Reset values
   localparam logic       RST_SERIAL_CLK_GATE = 1'b0;
   localparam logic       RST_INPUT_CLK_FREQ  = 1'b0;
   localparam logic       RST_TX_START_DELAY  = 1'b0;
   localparam logic       RST_TIMING_ENABLE   = 1'b1;
   localparam logic [7:0] RST_MULTI_FUNC_0    = 8'h00;
   localparam logic [1:0] RST_GROUP_SELECT    = 2'h3;
   localparam logic       RST_RING_WAKE       = 1'b0;

   // Index/data port pairs
   localparam logic [15:0] PORT_INDEX_PRIMARY = 16'h002e;
   localparam logic [15:0] PORT_INDEX_ALT     = 16'h004e;

   // Group select codes
   localparam logic [1:0] GRP_ALL_SERIAL = 2'h0;
   localparam logic [1:0] GRP_ALL_GPIO   = 2'h3;

   // Shared pin indices
   localparam int NUM_PINS = 7;
   localparam int PIN_DCD  = 0;
   localparam int PIN_RING = 1;
   localparam int PIN_CTS  = 2;
   localparam int PIN_DTR  = 3;
   localparam int PIN_RTS  = 4;
   localparam int PIN_DSR  = 5;
   localparam int PIN_SIN  = 6;
   localparam logic [6:0] SERIAL_OUT_MASK = 7'h18;

   // Function driven on a shared pin
   typedef enum logic [1:0] {
      FN_SERIAL,
      FN_GPIO,
      FN_ALT,
      FN_WAKE
   } pin_func_t;

endpackage : global_config_pkg

// *** host_model.sv ***
// Host software model reaching the registers through the index/data ports.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input  wire logic        clk,
   output var  logic [15:0] ioAddr,
   output var  logic        ioWr,
   output var  logic        ioRd,
   output var  logic [7:0]  ioWrData
);
   logic [15:0] base = 16'h004e; // Index port, data one above
   // One strobed cycle, taken at the next edge
   task automatic cyc(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d);
      ioAddr = a;
      ioWr = w;
      ioRd = r;
      ioWrData = d;
      @(posedge clk);
      #1;
   endtask : cyc
   // Release: strobes low, address and data no longer hold
   task automatic idle();
      ioWr = 1'h0;
      ioRd = 1'h0;
      ioAddr = ~ioAddr;
      ioWrData = ~ioWrData;
      repeat (2) @(posedge clk);
      #1;
   endtask : idle
   // Index write, then data write or read
   task automatic acc(input logic [7:0] idx, input logic [7:0] d, input logic r);
      cyc(base, 1'h1, 1'h0, idx);
      cyc(base + 16'h0001, !r, r, d);
      idle();
   endtask : acc
   task automatic rdRaw(input logic [15:0] a);
      cyc(a, 1'h0, 1'h1, 8'h00);
      idle();
   endtask : rdRaw
   initial begin
      ioAddr = 16'h0000;
      ioWr = 1'h0;
      ioRd = 1'h0;
      ioWrData = 8'h00;
   end
endmodule : host_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the global configuration and shared-pin block.
// Assumes straps are held through reset and the host model drives the port.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
   import global_config_pkg::*;
   logic        clk = 1'h0;
   logic        rst = 1'h1;
   logic [15:0] ioAddr, bitCycles = 16'h0003;
   logic        ioWr, ioRd, ioRdValid, txStart, serialClkEn, altConfigPort;
   logic        powerGoodVariant, timingEnable, inputClockFreqSelect;
   logic        serialOutStrapPin = 1'h1, uartDtrN = 1'h1, uartRtsN = 1'h1, thrWrite = 1'h0;
   logic [7:0]  ioWrData, ioRdData, eNote, aSel;
   logic [6:0]  pinIn = 7'h10, gpioOut = 7'h00, gpioOe = 7'h00, altOut = 7'h00, altOe = 7'h00;
   logic [6:0]  pinOut, pinOe, uartIn, gpioIn, altIn;
   int          n_fail = 0, cmp_count = 0;
   logic [7:0]  expQ[$];
   logic [7:0]  tIdx[7] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h30};
   logic [7:0]  tRst[7] = '{8'h00, 8'h00, 8'h13, 8'h00, 8'hc0, 8'h00, 8'h00};
   logic [7:0]  tSet[7] = '{8'h02, 8'h84, 8'h13, 8'hbf, 8'hc0, 8'h80, 8'h00};
   always #4 clk = ~clk;
   global_config_pin_mux u_dut (.*);
   host_model u_host (.*);
   // Each answer is taken against the oldest note
   always @(negedge clk) begin
      if (ioRdValid === 1'h1) begin
         if (expQ.size() == 0) `CHK("unasked answer", 1'h0, 1'h1)
         else begin
            eNote = expQ.pop_front();
            `CHK("read data", eNote, ioRdData)
         end
      end
   end
   task automatic rdChk(input logic [7:0] idx, input logic [7:0] e);
      expQ.push_back(e);
      u_host.acc(idx, 8'h00, 1'h1);
   endtask : rdChk
   // Pulse a holding-register write and count cycles to the start
   task automatic txChk(input int n);
      int k = 1; // The write edge itself is the first cycle
      thrWrite = 1'h1;
      @(posedge clk);
      #1;
      thrWrite = 1'h0;
      while (txStart !== 1'h1 && k < 50) begin
         @(posedge clk);
         #1;
         k++;
      end
      `CHK("tx start cycles", n, k)
   endtask : txChk
   // Expected pin functions for one setting of alt bits, group and override
   task automatic pinChk(input logic [7:0] a, input logic [1:0] g, input logic ovr);
      logic [6:0] eo, ee, eu;
      pin_func_t  f;
      for (int p = 0; p < NUM_PINS; p++) begin
         f = (g == 2'h0 || (p == PIN_SIN && g != 2'h3) || (p == PIN_RTS && !g[0])) ? FN_SERIAL : FN_GPIO;
         if (a[p == PIN_SIN ? 7 : p]) f = FN_ALT;
         if (p == PIN_RING && ovr) f = FN_WAKE;
         eu[p] = (f == FN_SERIAL) ? pinIn[p] : 1'h1;
         eo[p] = (f == FN_GPIO) ? gpioOut[p] : (f == FN_ALT) ? altOut[p] : (f == FN_WAKE) ? altOut[6] :
                 (p == PIN_DTR) ? uartDtrN : (p == PIN_RTS) ? uartRtsN : 1'h1;
         ee[p] = (f == FN_GPIO) ? gpioOe[p] : (f == FN_ALT) ? altOe[p] : (f == FN_WAKE) ? altOe[6] :
                 (p == PIN_DTR || p == PIN_RTS);
      end
      `CHK("pin out", eo, pinOut)
      `CHK("pin enable", ee, pinOe)
      `CHK("serial in", eu, uartIn)
      `CHK("gpio in", pinIn, gpioIn)
      `CHK("alt in", pinIn, altIn)
   endtask : pinChk
   task final_report;
      `CHK("notes left", 0, expQ.size())
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report
   // Watchdog well beyond the few hundred cycles of the run
   initial begin
      #(20000 * 8);
      n_fail++;
      final_report();
   end
   initial begin
      void'($urandom(32'h835e));
      repeat (20) @(posedge clk);
      #1;
      rst = 1'h0;
      repeat (3) @(posedge clk);
      #1;
      serialOutStrapPin = 1'h0; // Board strap only counts at power-on
      `CHK("port strap", 1'h1, altConfigPort)
      `CHK("power-good strap", 1'h1, powerGoodVariant)
      `CHK("timing reset", 1'h1, timingEnable)
      `CHK("clock reset", 1'h1, serialClkEn)
      for (int i = 0; i < 7; i++) rdChk(tIdx[i], tRst[i]);
      u_host.rdRaw(16'h002f);
      u_host.rdRaw(16'h0060);
      $display("test reset and straps done");
      for (int i = 0; i < 7; i++) u_host.acc(tIdx[i], 8'hff, 1'h0);
      for (int i = 0; i < 7; i++) rdChk(tIdx[i], tSet[i]);
      expQ.push_back(8'h30);
      u_host.rdRaw(u_host.base);
      `CHK("clock gated", 1'h0, serialClkEn)
      `CHK("clock select", 1'h1, inputClockFreqSelect)
      for (int i = 0; i < 7; i++) if (i != 2) u_host.acc(tIdx[i], 8'h00, 1'h0);
      u_host.acc(IDX_CONFIG_PORT_SEL, 8'h00, 1'h0);
      u_host.base = PORT_INDEX_PRIMARY;
      for (int i = 0; i < 7; i++) rdChk(tIdx[i], 8'h00);
      `CHK("port pair", 1'h0, altConfigPort)
      `CHK("power-good variant", 1'h0, powerGoodVariant)
      `CHK("timing off", 1'h0, timingEnable)
      `CHK("clock running", 1'h1, serialClkEn)
      $display("test registers done");
      txChk(1);
      u_host.acc(IDX_SERIAL_IRQ_CTRL, 8'h04, 1'h0);
      txChk(int'(bitCycles) + 1);
      $display("test transmit start done");
      for (int c = 0; c < 16; c++) begin
         aSel = c[3] ? (8'($urandom) & MULTI_FUNC_0_MASK) : 8'h00;
         {gpioOut, gpioOe, altOut, altOe} = 28'($urandom);
         {uartDtrN, uartRtsN, pinIn} = 9'($urandom);
         u_host.acc(IDX_MULTI_FUNC_0, aSel, 1'h0);
         u_host.acc(IDX_MULTI_FUNC_1, {c[1:0], 6'h00}, 1'h0);
         u_host.acc(IDX_MULTI_FUNC_2, {c[2], 7'h00}, 1'h0);
         pinChk(aSel, c[1:0], c[2]);
      end
      $display("test pin functions done");
      final_report();
   end
endmodule : tb_top
`default_nettype wire

// *** tx_start_delay.sv ***
// Transmit-start timing: start at once, or one bit time after the write.
// Assumes thrWrite is a one-cycle pulse and bitCycles is the bit period in clocks.
`timescale 1ns/1ns
`default_nettype none
module tx_start_delay
   import global_config_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        delayEn,
   input  wire logic        thrWrite,
   input  wire logic [15:0] bitCycles,
   output var  logic        txStart
);
   logic [15:0] count_q;
   logic        busy_q;

   // Bit-time countdown; a new write restarts it
   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= 16'h0000;
         busy_q  <= 1'b0;
      end else if (thrWrite && delayEn) begin
         count_q <= (bitCycles == 16'h0000) ? 16'h0001 : bitCycles;
         busy_q  <= 1'b1;
      end else if (busy_q) begin
         count_q <= count_q - 16'h0001;
         busy_q  <= (count_q != 16'h0001);
      end
   end

   // Start pulse, immediate or at end of the bit time
   always_ff @(posedge clk) begin
      if (rst) begin
         txStart <= 1'b0;
      end else begin
         txStart <= (thrWrite && !delayEn) || (busy_q && count_q == 16'h0001 && !thrWrite); // [R2]
      end
   end
endmodule : tx_start_delay
`default_nettype wire
